// ---- core/sacc_defs.svh ----
// Purpose: timing and width constants for the SAR conversion control
// Assumes: mclk at 125 MHz
// Notes:   cycle counts are derived from the printed times and rates
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH
`define SACC_RES_W       12
`define SACC_CLK_MHZ     125
`define SACC_WAKE_US     10
`define SACC_WAKE_CYC    (`SACC_WAKE_US * `SACC_CLK_MHZ)
`define SACC_SEQ_MAX_MHZ 14
`define SACC_STEP_CYC    ((`SACC_CLK_MHZ + `SACC_SEQ_MAX_MHZ - 1) / `SACC_SEQ_MAX_MHZ)
`define SACC_MAX_KSPS    700
`define SACC_CONV_CYC    ((`SACC_CLK_MHZ * 1000 + `SACC_MAX_KSPS - 1) / `SACC_MAX_KSPS)
`define SACC_SAMPLE_NS   32
`define SACC_SAMPLE_CYC  ((`SACC_SAMPLE_NS * `SACC_CLK_MHZ + 999) / 1000)
`endif

// ---- core/sacc_pkg.sv ----
// Purpose: shared types of the SAR conversion control
// Assumes: constants come from sacc_defs.svh
// Notes:   result word travels as one packed struct
`include "sacc_defs.svh"
package sacc_pkg;
  // -----------------------------------------
  // Controller states
  // -----------------------------------------
  typedef enum logic [2:0] {
    ST_WAKE   = 3'h0,
    ST_IDLE   = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_STEP   = 3'h3,
    ST_STORE  = 3'h4
  } sacc_state_t;

  // -----------------------------------------
  // Result word
  // -----------------------------------------
  typedef struct packed {
    logic                   cont;
    logic [`SACC_RES_W-1:0] code;
  } sacc_result_t;
endpackage

// ---- core/sacc_sar.sv ----
// Purpose: binary search register driving the internal DAC
// Assumes: cmp_above high while sampled input >= DAC level
// Notes:   one result bit per step, MSB first
`timescale 1ns/1ps
`include "sacc_defs.svh"
module sacc_sar #(
  parameter int unsigned W        = `SACC_RES_W,
  parameter int unsigned STEP_CYC = `SACC_STEP_CYC
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic         cmp_above,
  output logic [W-1:0]      dac_code,
  output logic              done
);
  import sacc_pkg::*;
  localparam int unsigned TW = $clog2(STEP_CYC + 1);

  logic [W-1:0]  code_q;
  logic [W-1:0]  mask_q;
  logic [TW-1:0] tick_q;
  logic          done_q;
  wire  [W-1:0]  code_nxt;
  wire           step = (|mask_q) && (tick_q == '0);

  // -----------------------------------------
  // Per-bit trial decision
  // -----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      if (i == W - 1)
      begin : g_top
        assign code_nxt[i] = mask_q[i] ? cmp_above : code_q[i];
      end
      else
      begin : g_low
        // Keep the trial bit if input sits at or above DAC
        assign code_nxt[i] = mask_q[i] ? cmp_above : (code_q[i] | mask_q[i+1]);
      end
    end
  endgenerate

  // Step timer keeps the sequencing rate at or under its limit
  always_ff @(posedge mclk)
  begin
    if (!reset_n || abort)
    begin
      code_q <= '0;
      mask_q <= '0;
      tick_q <= '0;
      done_q <= 1'b0;
    end
    else if (start)
    begin
      code_q <= {1'b1, {(W-1){1'b0}}};
      mask_q <= {1'b1, {(W-1){1'b0}}};
      tick_q <= TW'(STEP_CYC - 1);
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= step && mask_q[0];
      if (step)
      begin
        code_q <= code_nxt;
        mask_q <= mask_q >> 1;
        tick_q <= TW'(STEP_CYC - 1);
      end
      else if (|mask_q)
        tick_q <= tick_q - 1'b1;
    end
  end

  assign dac_code = code_q;
  assign done     = done_q;
endmodule // sacc_sar

// ---- core/sacc_buf.sv ----
// Purpose: two-entry result buffer with valid/ready on both sides
// Assumes: single clock
// Notes:   read-side outputs come straight from the head register; in_ready comes from the tail valid register
`timescale 1ns/1ps
module sacc_buf #(
  parameter int unsigned W = 13
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import sacc_pkg::*;
  logic [W-1:0] head_q;
  logic [W-1:0] tail_q;
  logic         head_v_q;
  logic         tail_v_q;

  // Handshake decode
  wire push = in_valid && !tail_v_q;
  wire pop  = head_v_q && out_ready;

  // Head refills from tail first so words stay in order
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      head_q   <= '0;
      tail_q   <= '0;
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end
    else if (pop)
    begin
      head_q   <= tail_v_q ? tail_q : in_data;
      head_v_q <= tail_v_q || push;
      tail_v_q <= 1'b0;
    end
    else if (push && !head_v_q)
    begin
      head_q   <= in_data;
      head_v_q <= 1'b1;
    end
    else if (push)
    begin
      tail_q   <= in_data;
      tail_v_q <= 1'b1;
    end
  end

  assign in_ready  = !tail_v_q;
  assign out_valid = head_v_q;
  assign out_data  = head_q;
endmodule // sacc_buf

// ---- core/sacc_ctrl.sv ----
// Purpose: conversion control of a 12-bit successive approximation converter
// Assumes: comparator output is settled and sampled on mclk
// Notes:   start bit is a one-cycle pulse; frame start is an async pin
//
// Functional notes
// - Start conversion on software start bit or frame-start trigger.
// - Continuous operation works with frame-start trigger left unconnected.
// - Wait 10 us after power-up or wake before first start.
// - On completion set status bit; end-of-frame stays high until read.
// - End-of-frame serves interrupt or DMA; reading the result clears it (code keeps it high if another word is waiting).
// - Single-conversion select picks continuous or one conversion per trigger.
// - Continuous results move by DMA without CPU help between samples.
// - Binary search against internal DAC, one bit per step, MSB first.
// - Result is 12 bits, throughput at most 700 ksps.
`timescale 1ns/1ps
`include "sacc_defs.svh"
module sacc_ctrl #(
  parameter int unsigned RES_W      = `SACC_RES_W,
  parameter int unsigned WAKE_CYC   = `SACC_WAKE_CYC,
  parameter int unsigned STEP_CYC   = `SACC_STEP_CYC,
  parameter int unsigned CONV_CYC   = `SACC_CONV_CYC,
  parameter int unsigned SAMPLE_CYC = `SACC_SAMPLE_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 sw_start,
  input  wire logic                 frame_start_pin,
  input  wire logic                 single_conversion_select,
  input  wire logic                 wake_pulse,
  input  wire logic                 cmp_above,
  input  wire logic                 result_read,
  output logic                      sample_hold,
  output logic [RES_W-1:0]          dac_code,
  output logic                      busy,
  output logic                      start_ready,
  output logic                      status_done,
  output logic                      eof,
  output sacc_pkg::sacc_result_t    result
);
  import sacc_pkg::*;
  localparam int unsigned WW = $clog2(WAKE_CYC + 1);
  localparam int unsigned PW = $clog2(CONV_CYC + 1);
  localparam int unsigned SW = $clog2(SAMPLE_CYC + 1);

  // ------------------------------------------------
  // Declarations
  // ------------------------------------------------
  sacc_state_t   state_q;
  sacc_state_t   state_d;
  logic [2:0]    fsync_q;
  logic          frame_lvl_q;
  logic [WW-1:0] wake_cnt_q;
  logic [PW-1:0] pace_cnt_q;
  logic [SW-1:0] samp_cnt_q;
  logic          run_cont_q;
  logic          pend_q;
  logic          status_q;
  logic          sample_hold_q;
  logic          busy_q;
  logic          ready_q;
  logic          sar_done;
  logic          buf_in_ready;
  logic          buf_out_valid;
  logic [RES_W-1:0] sar_code;
  sacc_result_t  buf_in;
  sacc_result_t  buf_out;

  // ------------------------------------------------
  // Frame-start pin synchroniser
  // ------------------------------------------------
  // Three stages; level accepted once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      fsync_q     <= 3'h0;
      frame_lvl_q <= 1'b0;
    end
    else
    begin
      fsync_q <= {fsync_q[1:0], frame_start_pin};
      if (fsync_q[1] == fsync_q[2])
        frame_lvl_q <= fsync_q[2];
    end
  end

  // ------------------------------------------------
  // Request decode
  // ------------------------------------------------
  wire frame_rise = (fsync_q[1] == fsync_q[2]) && fsync_q[2] && !frame_lvl_q;
  wire trig       = sw_start || frame_rise;
  wire wake_done  = (wake_cnt_q == '0);
  wire pace_ok    = (pace_cnt_q == '0);
  wire cont_go    = run_cont_q && !single_conversion_select;
  wire in_idle    = (state_q == ST_IDLE);
  wire start_now  = in_idle && pace_ok && (pend_q || trig || cont_go) && !wake_pulse;
  wire samp_end   = (state_q == ST_SAMPLE) && (samp_cnt_q == '0);
  wire sar_start  = samp_end && !wake_pulse;
  wire store_vld  = (state_q == ST_STORE);
  wire push       = store_vld && buf_in_ready;
  wire pop        = buf_out_valid && result_read;

  // ------------------------------------------------
  // Next state
  // ------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_WAKE:   state_d = wake_done ? ST_IDLE : ST_WAKE;
      ST_IDLE:   state_d = start_now ? ST_SAMPLE : ST_IDLE;
      ST_SAMPLE: state_d = samp_end ? ST_STEP : ST_SAMPLE;
      ST_STEP:   state_d = sar_done ? ST_STORE : ST_STEP;
      // stall while buffer full, no word lost
      ST_STORE:  state_d = buf_in_ready ? ST_IDLE : ST_STORE;
      default:   state_d = ST_WAKE;
    endcase
    if (wake_pulse)
      state_d = ST_WAKE;
  end

  // ------------------------------------------------
  // State and timing counters
  // ------------------------------------------------
  // power-up wait count
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_q    <= ST_WAKE;
      wake_cnt_q <= WW'(WAKE_CYC - 1);
    end
    else
    begin
      state_q <= state_d;
      if (wake_pulse)
        wake_cnt_q <= WW'(WAKE_CYC - 1);
      else if (!wake_done)
        wake_cnt_q <= wake_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pace_cnt_q <= '0;
      samp_cnt_q <= '0;
    end
    else
    begin
      if (start_now)
        pace_cnt_q <= PW'(CONV_CYC - 1);
      else if (!pace_ok)
        pace_cnt_q <= pace_cnt_q - 1'b1;
      if (start_now)
        samp_cnt_q <= SW'(SAMPLE_CYC - 1);
      else if (state_q == ST_SAMPLE && samp_cnt_q != '0)
        samp_cnt_q <= samp_cnt_q - 1'b1;
    end
  end

  // ------------------------------------------------
  // Mode and pending request
  // ------------------------------------------------
  // single select ends a continuous run
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      run_cont_q <= 1'b0;
      pend_q     <= 1'b0;
    end
    else
    begin
      if (wake_pulse || single_conversion_select)
        run_cont_q <= 1'b0;
      else if (start_now)
        run_cont_q <= 1'b1;
      if (wake_pulse || start_now)
        pend_q <= 1'b0;
      else if (trig && in_idle)
        pend_q <= 1'b1;
    end
  end

  // ------------------------------------------------
  // Status and registered outputs
  // ------------------------------------------------
  // done flag; a new result beats the clear
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      status_q      <= 1'b0;
      sample_hold_q <= 1'b0;
      busy_q        <= 1'b0;
      ready_q       <= 1'b0;
    end
    else
    begin
      status_q      <= push || (status_q && !pop);
      sample_hold_q <= (state_d == ST_SAMPLE);
      busy_q        <= (state_d == ST_SAMPLE) || (state_d == ST_STEP) || (state_d == ST_STORE);
      ready_q       <= (state_d == ST_IDLE);
    end
  end

  // ------------------------------------------------
  // Search engine and result buffer
  // ------------------------------------------------
  // binary search engine
  sacc_sar #(
    .W        (RES_W),
    .STEP_CYC (STEP_CYC)
  ) u_sar (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .start     (sar_start),
    .abort     (wake_pulse),
    .cmp_above (cmp_above),
    .dac_code  (sar_code),
    .done      (sar_done)
  );

  // One driver for the whole word, mode flag above the code
  assign buf_in = {run_cont_q, sar_code};

  // read of result pops the buffer
  sacc_buf #(
    .W ($bits(sacc_result_t))
  ) u_buf (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (store_vld),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (buf_out_valid),
    .out_ready (result_read),
    .out_data  (buf_out)
  );

  // Output wiring, all from flip-flops
  assign sample_hold = sample_hold_q;
  assign dac_code    = sar_code;
  assign busy        = busy_q;
  assign start_ready = ready_q;
  assign status_done = status_q;
  assign eof         = buf_out_valid;
  assign result      = buf_out;

  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  AST_WAKE_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    wake_pulse |=> (state_q == ST_WAKE) && !sample_hold && (wake_cnt_q == WW'(WAKE_CYC - 1)))
    else $error("wake did not restart power-up wait");

  AST_WAKE_FIRST: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(sample_hold) |-> wake_done && $past(state_q) == ST_IDLE)
    else $error("sampling began before power-up wait");

  AST_SW_START: assert property (@(posedge mclk) disable iff (!reset_n)
    (in_idle && pace_ok && sw_start && !wake_pulse) |=> sample_hold ##0 busy)
    else $error("software start not taken");

  AST_FRAME_START: assert property (@(posedge mclk) disable iff (!reset_n)
    (in_idle && pace_ok && frame_rise && !wake_pulse) |=> (state_q == ST_SAMPLE))
    else $error("frame start not taken");

  AST_CONT_RUN: assert property (@(posedge mclk) disable iff (!reset_n)
    (in_idle && pace_ok && cont_go && !wake_pulse) |=> (state_q == ST_SAMPLE))
    else $error("continuous run did not restart");

  AST_SINGLE_STOP: assert property (@(posedge mclk) disable iff (!reset_n)
    (single_conversion_select && !pend_q && !trig && in_idle) |=> in_idle || state_q == ST_WAKE)
    else $error("single mode converted without trigger");

  AST_DONE_FLAGS: assert property (@(posedge mclk) disable iff (!reset_n)
    push |=> status_done ##0 eof)
    else $error("completion flags not raised");

  AST_EOF_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    (eof && !result_read) |=> eof && $stable(result))
    else $error("end of frame dropped before read");

  AST_STALL: assert property (@(posedge mclk) disable iff (!reset_n)
    (store_vld && !buf_in_ready && !wake_pulse) |=> store_vld && $stable(dac_code))
    else $error("result lost under back-pressure");

  AST_MSB_FIRST: assert property (@(posedge mclk) disable iff (!reset_n)
    sar_start |=> dac_code == {1'b1, {(RES_W-1){1'b0}}})
    else $error("search did not begin at the top bit");

  AST_PACE: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(sample_hold) |=> !pace_ok [*2])
    else $error("conversion spacing not enforced");

  AST_NO_RESTART: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == ST_STEP && trig && !wake_pulse) |=> state_q inside {ST_STEP, ST_STORE})
    else $error("start during conversion disturbed it");
endmodule // sacc_ctrl

// ---- tb/sacc_far_model.sv ----
// Purpose: far side of the conversion control, comparator and result reader
// Assumes: reads are taken on rising mclk, changed on falling mclk
// Notes:   stall holds reads off so the two-entry buffer can fill
`timescale 1ns/1ps
module sacc_far_model (
  input  wire logic                  mclk,
  input  wire logic [11:0]           ain,
  input  wire logic                  stall,
  input  wire logic [11:0]           dac_code,
  input  wire logic                  eof,
  input  wire sacc_pkg::sacc_result_t result,
  output logic                       cmp_above,
  output logic                       result_read
);
  import sacc_pkg::*;
  sacc_result_t words[$];
  int           rd_cyc[$];
  int           cyc = 0;

  // ----------------------------------------
  // Ideal comparator on a held input
  // ----------------------------------------
  assign cmp_above = (ain >= dac_code);

  // reader fetches words
  // Request held across the sampling edge, dropped only at the next fall
  initial result_read = 1'b0;
  always @(negedge mclk)
  begin
    result_read <= eof & ~stall;
  end

  // Capture every word taken, with its cycle
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (result_read && eof)
    begin
      words.push_back(result);
      rd_cyc.push_back(cyc);
    end
  end
endmodule // sacc_far_model

// ---- tb/tb.sv ----
// Purpose: self-checking bench of the SAR conversion control
// Assumes: wake wait shortened to WAKE cycles
// Notes:   inputs change on falling mclk only
`timescale 1ns/1ps
module tb;
  import sacc_pkg::*;
  localparam int WAKE = 20;
  logic         mclk, reset_n, sw_start, frame_start_pin, sel, wake_pulse;
  logic         stall, cmp_above, result_read, sample_hold, busy;
  logic         start_ready, status_done, eof;
  logic [11:0]  ain, dac_code;
  sacc_result_t result;
  int           mismatches = 0;
  int           num_checks = 0;
  logic [11:0]  vals [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h3A7};

  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  sacc_ctrl #(.WAKE_CYC(WAKE)) uut (.mclk(mclk), .reset_n(reset_n), .sw_start(sw_start),
    .frame_start_pin(frame_start_pin), .single_conversion_select(sel), .wake_pulse(wake_pulse),
    .cmp_above(cmp_above), .result_read(result_read), .sample_hold(sample_hold),
    .dac_code(dac_code), .busy(busy), .start_ready(start_ready), .status_done(status_done),
    .eof(eof), .result(result));

  sacc_far_model far (.mclk(mclk), .ain(ain), .stall(stall), .dac_code(dac_code), .eof(eof),
    .result(result), .cmp_above(cmp_above), .result_read(result_read));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Bounded waits; running out ends the run
  task automatic wait_words(input int n, input int bound);
    int i;
    for (i = 0; i < bound && far.words.size() < n; i++) cyc(1);
    if (far.words.size() < n)
    begin
      chk_cnt(far.words.size(), n);
      test_done();
    end
  endtask

  task automatic wait_ready(input int bound);
    int i;
    for (i = 0; i < bound && start_ready !== 1'b1; i++) cyc(1);
    chk_bit(start_ready, 1'b1);
    if (start_ready !== 1'b1) test_done();
  endtask

  task automatic pulse_start();
    sw_start = 1'b1;
    cyc(1);
    sw_start = 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_wake();
    cyc(7);
    chk_bit(busy | eof | status_done | start_ready, 1'b0);
    reset_n = 1'b1;
    cyc(2);
    pulse_start();
    cyc(WAKE - 8);
    chk_bit(start_ready, 1'b0);
    chk_bit(busy, 1'b0);
    wait_ready(WAKE + 10);
    cyc(3);
    chk_bit(busy, 1'b0);
    $display("t_wake done");
  endtask

  task automatic t_single(input logic [11:0] v);
    int i;
    sel = 1'b1;
    ain = v;
    stall = 1'b1;
    far.words.delete();
    cyc(60);
    pulse_start();
    chk_bit(sample_hold & busy & ~start_ready, 1'b1);
    cyc(5);
    chk_bit(sample_hold, 1'b0);
    chk_code(dac_code, 12'h800);
    cyc(7);
    chk_code(dac_code, 12'h800);
    cyc(3);
    chk_code(dac_code, {v[11], 1'b1, 10'h000});
    for (i = 0; i < 200 && eof !== 1'b1; i++) cyc(1);
    chk_bit(status_done, 1'b1);
    chk_bit(busy, 1'b0);
    chk_code(result.code, v);
    cyc(10);
    chk_bit(eof, 1'b1);
    stall = 1'b0;
    wait_words(1, 10);
    cyc(2);
    chk_bit(eof | status_done, 1'b0);
    chk_bit(far.words[0].cont, 1'b0);
    $display("t_single done");
  endtask

  task automatic t_ignore();
    ain = 12'h6C3;
    far.words.delete();
    cyc(60);
    pulse_start();
    cyc(30);
    pulse_start();
    frame_start_pin = 1'b1;
    cyc(4);
    frame_start_pin = 1'b0;
    wait_words(1, 200);
    cyc(300);
    chk_cnt(far.words.size(), 1);
    chk_code(far.words[0].code, 12'h6C3);
    $display("t_ignore done");
  endtask

  task automatic t_frame();
    int k;
    far.words.delete();
    for (k = 0; k < 3; k++)
    begin
      ain = 12'h0F1 + 12'h100 * k;
      frame_start_pin = 1'b1;
      cyc(4);
      frame_start_pin = 1'b0;
      wait_words(k + 1, 250);
      cyc(200);
      chk_cnt(far.words.size(), k + 1);
      chk_code(far.words[k].code, ain);
    end
    $display("t_frame done");
  endtask

  // Start in idle before pacing ends is held, then taken on time
  task automatic t_pend();
    ain = 12'h15A;
    far.words.delete();
    far.rd_cyc.delete();
    cyc(60);
    pulse_start();
    wait_words(1, 200);
    pulse_start();
    cyc(2);
    chk_bit(busy, 1'b0);
    wait_words(2, 250);
    chk_cnt(far.rd_cyc[1] - far.rd_cyc[0], 179);
    chk_code(far.words[1].code, 12'h15A);
    $display("t_pend done");
  endtask

  task automatic t_cont();
    int i;
    int n0;
    sel = 1'b0;
    ain = 12'h9E4;
    far.words.delete();
    far.rd_cyc.delete();
    cyc(60);
    pulse_start();
    wait_words(4, 900);
    for (i = 1; i < 4; i++)
    begin
      chk_bit(far.words[i].cont, 1'b1);
      chk_code(far.words[i].code, 12'h9E4);
      chk_bit(far.rd_cyc[i] - far.rd_cyc[i-1] >= 179, 1'b1);
    end
    stall = 1'b1;
    n0 = far.words.size();
    cyc(600);
    chk_bit(eof & busy & status_done, 1'b1);
    sel = 1'b1;
    cyc(2);
    stall = 1'b0;
    cyc(300);
    chk_cnt(far.words.size() - n0, 3);
    chk_bit(busy, 1'b0);
    $display("t_cont done");
  endtask

  task automatic t_wakeup();
    far.words.delete();
    cyc(60);
    pulse_start();
    cyc(20);
    wake_pulse = 1'b1;
    cyc(1);
    wake_pulse = 1'b0;
    cyc(2);
    chk_bit(busy | start_ready, 1'b0);
    cyc(WAKE - 8);
    chk_bit(start_ready, 1'b0);
    wait_ready(20);
    cyc(150);
    chk_cnt(far.words.size(), 0);
    $display("t_wakeup done");
  endtask

  // ----------------------------------------
  // Main sequence and run limit
  // ----------------------------------------
  initial
  begin
    reset_n = 1'b0;
    sw_start = 1'b0;
    frame_start_pin = 1'b0;
    sel = 1'b1;
    wake_pulse = 1'b0;
    stall = 1'b0;
    ain = 12'h000;
    t_wake();
    foreach (vals[i]) t_single(vals[i]);
    t_ignore();
    t_frame();
    t_pend();
    t_cont();
    t_wakeup();
    test_done();
  end

  initial
  begin
    #160000;
    mismatches++;
    $display("Error at %0t: run limit got %h exp %h", $time, 1'b1, 1'b0);
    test_done();
  end
endmodule // tb
